// >>> hdl/asu_pkg.sv
package asu_pkg;
	// register addresses on the plain register port
	localparam logic [15:0] ADDR_MODE = 16'hFF90; // serial_mode_control
	localparam logic [15:0] ADDR_TXBUF = 16'hFF91; // transmit_buffer
	localparam logic [15:0] ADDR_RXBUF = 16'hFF92; // receive_buffer
	localparam logic [15:0] ADDR_RXERR = 16'hFF93; // rx_error_status
	localparam logic [15:0] ADDR_TXSTAT = 16'hFF94; // tx_status
	localparam logic [15:0] ADDR_DIV = 16'hFF97; // baud_divisor
	localparam logic [15:0] ADDR_AUX = 16'hFF98; // serial_aux_control

	// reset values
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] DIV_RST = 8'hFF;
	localparam logic [4:0] AUX_RST = 5'h16; // low five bits of the aux register

	// serial_mode_control fields
	localparam int MODE_POWER = 7; // master_clock_enable
	localparam int MODE_TXE = 6; // transmit_enable
	localparam int MODE_RXE = 5; // receive_enable
	localparam int MODE_PS_HI = 4; // parity_select_hi
	localparam int MODE_PS_LO = 3; // parity_select_lo
	localparam int MODE_CL = 2; // char_length_select, 1 = 8 bits
	localparam int MODE_SL = 1; // stop_length_select, 1 = 2 stop bits

	// serial_aux_control fields
	localparam int AUX_DIR = 1; // bit_order_select, 1 = lsb first
	localparam int AUX_INV = 0; // tx_line_invert

	// rx_error_status and tx_status fields
	localparam int ERR_PE = 2;
	localparam int ERR_FE = 1;
	localparam int ERR_OVE = 0;
	localparam int TST_BUF = 1;
	localparam int TST_SHIFT = 0;

	// one bit lasts this many counter outputs of the divisor
	localparam int BIT_MUL = 2;

	// parity select encodings {hi, lo}
	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_ZERO = 2'b01,
		PAR_ODD = 2'b10,
		PAR_EVEN = 2'b11
	} asu_par_type;

	// maps a character to line order and back (the mapping is its own inverse)
	function automatic logic [7:0] asu_order(input logic [7:0] v, input logic eight, input logic lsb_first);
		logic [7:0] r;
		r = 8'h00;
		if (lsb_first) begin
			r = eight ? v : {1'b0, v[6:0]};
		end else if (eight) begin
			for (int i = 0; i < 8; i++) r[i] = v[7 - i];
		end else begin
			for (int i = 0; i < 7; i++) r[i] = v[6 - i];
		end
		return r;
	endfunction : asu_order

	// ones count over the character bits only
	function automatic logic asu_ones_odd(input logic [7:0] v, input logic eight);
		return eight ? ^v : ^v[6:0];
	endfunction : asu_ones_odd
endpackage : asu_pkg

// >>> hdl/asu_rx_if.sv
`timescale 1ns/1ps
// configuration into the receiver and a finished character out of it
interface asu_rx_if;
	logic enable; // master and receive enable both set
	logic ce; // global clock enable
	logic line; // synchronised, forced-high receive line
	logic eight; // eight character bits
	logic lsb_first; // bit order
	logic [1:0] par_mode; // parity select
	logic [7:0] half; // half a bit in mclk cycles
	logic done; // one-cycle pulse, character finished
	logic [7:0] data; // received character
	logic perr; // parity error of this character
	logic ferr; // framing error of this character

	modport core (output enable, ce, line, eight, lsb_first, par_mode, half, input done, data, perr, ferr);
	modport rx (input enable, ce, line, eight, lsb_first, par_mode, half, output done, data, perr, ferr);
endinterface : asu_rx_if

// >>> hdl/asu_rx.sv
`timescale 1ns/1ps
module asu_rx (
	input wire logic mclk,
	input wire logic rstn,
	asu_rx_if.rx rif
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asu_rx_st_type;

	typedef struct packed {
		asu_rx_st_type st; // receive phase
		logic [8:0] cnt; // cycles left in this phase
		logic [2:0] nbit; // character bit index
		logic [7:0] sh; // shift register, fills from the top
		logic par; // sampled parity bit
		logic prev; // line one cycle ago, for the falling edge
		logic done;
		logic [7:0] data;
		logic perr;
		logic ferr;
	} asu_rx_state_type;

	asu_rx_state_type s_r, s_nxt;
	logic [8:0] full; // one bit time
	logic [8:0] half9; // half a bit time
	logic [7:0] arr; // arrival-ordered bits
	logic [7:0] chr; // character in register order

	assign full = {rif.half, 1'b0};
	assign half9 = {1'b0, rif.half};
	assign arr = rif.eight ? s_r.sh : {1'b0, s_r.sh[7:1]};
	assign chr = asu_pkg::asu_order(arr, rif.eight, rif.lsb_first);

	// receive sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.prev = rif.line;
		if (!rif.enable) begin
			// disabled receiver is held in its reset state
			s_nxt = '0;
			s_nxt.prev = 1'b1;
		end else begin
			unique case (s_r.st)
				RX_IDLE: begin
					// falling edge starts the half-bit check
					if (s_r.prev && !rif.line) begin
						s_nxt.st = RX_START;
						s_nxt.cnt = half9 - 9'h001;
					end
				end
				RX_START: begin
					if (s_r.cnt == 9'h000) begin
						// a glitch that is high again is no start bit
						s_nxt.st = rif.line ? RX_IDLE : RX_DATA;
						s_nxt.cnt = full - 9'h001;
						s_nxt.nbit = 3'h0;
					end else begin
						s_nxt.cnt = s_r.cnt - 9'h001;
					end
				end
				RX_DATA: begin
					if (s_r.cnt == 9'h000) begin
						s_nxt.sh = {rif.line, s_r.sh[7:1]};
						s_nxt.cnt = full - 9'h001;
						s_nxt.nbit = s_r.nbit + 3'h1;
						if (s_r.nbit == (rif.eight ? 3'h7 : 3'h6)) begin
							// no parity bit expected without parity
							s_nxt.st = (rif.par_mode == asu_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
						end
					end else begin
						s_nxt.cnt = s_r.cnt - 9'h001;
					end
				end
				RX_PAR: begin
					if (s_r.cnt == 9'h000) begin
						s_nxt.par = rif.line;
						s_nxt.st = RX_STOP;
						s_nxt.cnt = full - 9'h001;
					end else begin
						s_nxt.cnt = s_r.cnt - 9'h001;
					end
				end
				RX_STOP: begin
					// only the first stop bit is checked, a second is just idle line
					if (s_r.cnt == 9'h000) begin
						s_nxt.st = RX_IDLE;
						s_nxt.done = 1'b1;
						s_nxt.ferr = !rif.line;
						s_nxt.data = chr;
						unique case (rif.par_mode)
							asu_pkg::PAR_EVEN: s_nxt.perr = asu_pkg::asu_ones_odd(arr, rif.eight) ^ s_r.par;
							asu_pkg::PAR_ODD: s_nxt.perr = !(asu_pkg::asu_ones_odd(arr, rif.eight) ^ s_r.par);
							default: s_nxt.perr = 1'b0;
						endcase
					end else begin
						s_nxt.cnt = s_r.cnt - 9'h001;
					end
				end
			endcase
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else if (rif.ce) begin
			s_r <= s_nxt;
		end
	end

	assign rif.done = s_r.done;
	assign rif.data = s_r.data;
	assign rif.perr = s_r.perr;
	assign rif.ferr = s_r.ferr;

	property p_rx_dis;
		@(posedge mclk) disable iff (!rstn) (rif.ce && !rif.enable) |=> (s_r.st == RX_IDLE) && !s_r.done;
	endproperty
	a_rx_dis: assert property (p_rx_dis) else $error("receiver not reset while disabled");

	property p_rx_noperr;
		@(posedge mclk) disable iff (!rstn)
			(rif.ce && s_r.st == RX_STOP && s_r.cnt == 9'h000 && rif.enable && !rif.par_mode[1]) |=> !s_r.perr;
	endproperty
	a_rx_noperr: assert property (p_rx_noperr) else $error("parity error without checked parity");

	property p_rx_even;
		@(posedge mclk) disable iff (!rstn)
			(rif.ce && s_r.st == RX_STOP && s_r.cnt == 9'h000 && rif.enable && rif.par_mode == asu_pkg::PAR_EVEN)
			|=> s_r.perr == $past(asu_pkg::asu_ones_odd(arr, rif.eight) ^ s_r.par);
	endproperty
	a_rx_even: assert property (p_rx_even) else $error("even parity check wrong");

	property p_rx_one_stop;
		@(posedge mclk) disable iff (!rstn)
			(rif.ce && rif.enable && s_r.st == RX_STOP && s_r.cnt == 9'h000) |=> s_r.done && s_r.st == RX_IDLE;
	endproperty
	a_rx_one_stop: assert property (p_rx_one_stop) else $error("receiver waited past first stop bit");
endmodule : asu_rx

// >>> hdl/asu_top.sv
`timescale 1ns/1ps
module asu_top (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [15:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rd_data,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_out_oe_n,
	output logic serial_in_used
);
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} asu_tx_st_type;

	typedef struct packed {
		logic [7:0] mode; // serial_mode_control
		logic [4:0] aux; // serial_aux_control, writable bits
		logic [7:0] div; // baud_divisor
		logic [7:0] txbuf; // transmit_buffer
		logic txfull; // transmit buffer holds a character
		logic [7:0] rxbuf; // receive_buffer
		logic rxfull; // receive buffer not yet read
		logic [2:0] err; // rx_error_status
		logic [7:0] rd_data; // read data, valid one cycle
		asu_tx_st_type tx_st; // transmit phase
		logic [8:0] tcnt; // cycles left in this bit
		logic [2:0] tnbit; // character bit index
		logic [7:0] tsh; // transmit shift register
		logic tpar; // parity bit to send
		logic tline; // logical transmit level
		logic out; // pin level
		logic oe_n; // pin output enable, low drives
		logic in_used; // receive pin in serial use
		logic sync1; // first synchroniser stage
		logic sync2; // second synchroniser stage
	} asu_state_type;

	asu_state_type s_r, s_nxt;
	asu_rx_if rif ();

	logic power; // master_clock_enable
	logic tx_en; // master and transmit enable
	logic rx_en; // master and receive enable
	logic eight; // eight character bits
	logic lsb_first; // bit order
	asu_pkg::asu_par_type par_mode; // parity select
	logic [8:0] full; // one bit time in mclk cycles

	assign power = s_r.mode[asu_pkg::MODE_POWER];
	assign tx_en = power && s_r.mode[asu_pkg::MODE_TXE];
	assign rx_en = power && s_r.mode[asu_pkg::MODE_RXE];
	assign eight = s_r.mode[asu_pkg::MODE_CL];
	assign lsb_first = s_r.aux[asu_pkg::AUX_DIR];
	assign par_mode = asu_pkg::asu_par_type'({s_r.mode[asu_pkg::MODE_PS_HI], s_r.mode[asu_pkg::MODE_PS_LO]});
	assign full = 9'(asu_pkg::BIT_MUL * s_r.div);

	// receiver hookup; the input seen inside is forced high while powered down
	assign rif.enable = rx_en;
	assign rif.ce = ce;
	assign rif.line = power ? s_r.sync2 : 1'b1;
	assign rif.eight = eight;
	assign rif.lsb_first = lsb_first;
	assign rif.par_mode = par_mode;
	assign rif.half = s_r.div;

	asu_rx u_rx (
		.mclk(mclk),
		.rstn(rstn),
		.rif(rif.rx)
	);

	// registers, transmitter and status in one next-state process
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = serial_in_pin;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.rd_data = 8'h00;

		// reads and their side effects
		if (rd_stb) begin
			unique case (addr)
				asu_pkg::ADDR_MODE: s_nxt.rd_data = s_r.mode;
				asu_pkg::ADDR_RXBUF: begin
					s_nxt.rd_data = s_r.rxbuf;
					s_nxt.rxfull = 1'b0;
				end
				asu_pkg::ADDR_RXERR: begin
					s_nxt.rd_data = {5'h00, s_r.err};
					s_nxt.err = 3'h0;
				end
				asu_pkg::ADDR_TXSTAT: begin
					s_nxt.rd_data = 8'h00;
					s_nxt.rd_data[asu_pkg::TST_BUF] = s_r.txfull;
					s_nxt.rd_data[asu_pkg::TST_SHIFT] = (s_r.tx_st != TX_IDLE);
				end
				asu_pkg::ADDR_DIV: s_nxt.rd_data = s_r.div;
				// aux register, the three upper bits read as zero
				asu_pkg::ADDR_AUX: s_nxt.rd_data = {3'h0, s_r.aux};
				// unmapped addresses and the transmit buffer read as zero
				default: s_nxt.rd_data = 8'h00;
			endcase
		end

		// transmitter
		if (!tx_en) begin
			// synchronous reset of the transmit side
			s_nxt.tx_st = TX_IDLE;
			s_nxt.txfull = 1'b0;
			s_nxt.tline = 1'b1;
			s_nxt.tcnt = 9'h000;
		end else begin
			unique case (s_r.tx_st)
				TX_IDLE: begin
					s_nxt.tline = 1'b1;
					if (s_r.txfull) begin
						// framing bits are added around the buffered character
						s_nxt.tx_st = TX_START;
						s_nxt.tsh = asu_pkg::asu_order(s_r.txbuf, eight, lsb_first);
						s_nxt.txfull = 1'b0;
						s_nxt.tline = 1'b0;
						s_nxt.tcnt = full - 9'h001;
						s_nxt.tnbit = 3'h0;
						unique case (par_mode)
							asu_pkg::PAR_EVEN: s_nxt.tpar = asu_pkg::asu_ones_odd(s_r.txbuf, eight);
							asu_pkg::PAR_ODD: s_nxt.tpar = !asu_pkg::asu_ones_odd(s_r.txbuf, eight);
							default: s_nxt.tpar = 1'b0;
						endcase
					end
				end
				default: begin
					if (s_r.tcnt != 9'h000) begin
						s_nxt.tcnt = s_r.tcnt - 9'h001;
					end else begin
						s_nxt.tcnt = full - 9'h001;
						unique case (s_r.tx_st)
							TX_START, TX_DATA: begin
								if (s_r.tx_st == TX_DATA) begin
									s_nxt.tsh = {1'b0, s_r.tsh[7:1]};
									s_nxt.tnbit = s_r.tnbit + 3'h1;
								end
								if (s_r.tx_st == TX_DATA && s_r.tnbit == (eight ? 3'h7 : 3'h6)) begin
									// without parity the stop bit follows the last character bit
									s_nxt.tx_st = (par_mode == asu_pkg::PAR_NONE) ? TX_STOP1 : TX_PAR;
									s_nxt.tline = (par_mode == asu_pkg::PAR_NONE) ? 1'b1 : s_r.tpar;
								end else begin
									s_nxt.tx_st = TX_DATA;
									s_nxt.tline = (s_r.tx_st == TX_START) ? s_r.tsh[0] : s_r.tsh[1];
								end
							end
							TX_PAR: begin
								s_nxt.tx_st = TX_STOP1;
								s_nxt.tline = 1'b1;
							end
							TX_STOP1: begin
								s_nxt.tx_st = s_r.mode[asu_pkg::MODE_SL] ? TX_STOP2 : TX_IDLE;
								s_nxt.tline = 1'b1;
							end
							default: begin
								s_nxt.tx_st = TX_IDLE;
								s_nxt.tline = 1'b1;
							end
						endcase
					end
				end
			endcase
		end

		// finished character from the receiver; set wins over a read clear
		if (rif.done) begin
			if (s_r.rxfull && s_nxt.rxfull) begin
				s_nxt.err[asu_pkg::ERR_OVE] = 1'b1;
			end else begin
				s_nxt.rxbuf = rif.data;
				s_nxt.rxfull = 1'b1;
			end
			if (rif.perr) s_nxt.err[asu_pkg::ERR_PE] = 1'b1;
			if (rif.ferr) s_nxt.err[asu_pkg::ERR_FE] = 1'b1;
		end

		// master enable clear resets everything but the software settings;
		// done as a synchronous clear so no flop sees a register-made async reset
		if (!power) begin
			s_nxt.err = 3'h0;
			s_nxt.rxbuf = 8'h00;
			s_nxt.rxfull = 1'b0;
			s_nxt.txfull = 1'b0;
			s_nxt.tx_st = TX_IDLE;
			s_nxt.tline = 1'b1;
		end

		// register writes
		if (wr_stb) begin
			unique case (addr)
				asu_pkg::ADDR_MODE: s_nxt.mode = wr_data;
				asu_pkg::ADDR_DIV: s_nxt.div = wr_data;
				asu_pkg::ADDR_AUX: s_nxt.aux = wr_data[4:0];
				asu_pkg::ADDR_TXBUF: begin
					// a write starts a frame; ignored while the transmitter is off
					if (tx_en) begin
						s_nxt.txbuf = wr_data;
						s_nxt.txfull = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// pins: serial function only with the matching enable, else released
		s_nxt.out = tx_en ? (s_r.tline ^ s_r.aux[asu_pkg::AUX_INV]) : 1'b1;
		s_nxt.oe_n = !tx_en;
		s_nxt.in_used = rx_en;
	end

	// state register, frozen while ce is low
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.mode <= asu_pkg::MODE_RST;
			s_r.div <= asu_pkg::DIV_RST;
			s_r.aux <= asu_pkg::AUX_RST;
			s_r.tline <= 1'b1;
			s_r.out <= 1'b1;
			s_r.oe_n <= 1'b1;
			s_r.sync1 <= 1'b1;
			s_r.sync2 <= 1'b1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign rd_data = s_r.rd_data;
	assign serial_out_pin = s_r.out;
	assign serial_out_oe_n = s_r.oe_n;
	assign serial_in_used = s_r.in_used;

	property p_mode_reset;
		@(posedge mclk) disable iff (!rstn) $rose(rstn) |-> s_r.mode == asu_pkg::MODE_RST;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode register reset value wrong");

	property p_off_line_high;
		@(posedge mclk) disable iff (!rstn) (ce && !power) |=> serial_out_pin && serial_out_oe_n;
	endproperty
	a_off_line_high: assert property (p_off_line_high) else $error("output not high while powered down");

	property p_off_clears;
		@(posedge mclk) disable iff (!rstn) (ce && !power) |=> !s_r.txfull && !s_r.rxfull && s_r.err == 3'h0;
	endproperty
	a_off_clears: assert property (p_off_clears) else $error("status not cleared while powered down");

	property p_tx_dis;
		@(posedge mclk) disable iff (!rstn) (ce && !tx_en) |=> s_r.tx_st == TX_IDLE;
	endproperty
	a_tx_dis: assert property (p_tx_dis) else $error("transmitter active while disabled");

	property p_tx_start;
		@(posedge mclk) disable iff (!rstn)
			(ce && tx_en && s_r.tx_st == TX_IDLE && s_r.txfull) |=> s_r.tx_st == TX_START && !s_r.tline;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit not sent for buffered data");

	property p_oe;
		@(posedge mclk) disable iff (!rstn) ce |=> serial_out_oe_n == !$past(tx_en) && serial_in_used == $past(rx_en);
	endproperty
	a_oe: assert property (p_oe) else $error("pin function does not follow enables");

	property p_err_clear;
		@(posedge mclk) disable iff (!rstn) (ce && rd_stb && addr == asu_pkg::ADDR_RXERR && !rif.done) |=> s_r.err == 3'h0;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error status not cleared by read");

	property p_par_bit;
		@(posedge mclk) disable iff (!rstn)
			(ce && tx_en && s_r.tx_st == TX_IDLE && s_r.txfull && par_mode == asu_pkg::PAR_ZERO) |=> !s_r.tpar;
	endproperty
	a_par_bit: assert property (p_par_bit) else $error("zero parity bit not zero");

	property p_start_level;
		@(posedge mclk) disable iff (!rstn)
			(ce && tx_en && s_r.tx_st == TX_START) |=> serial_out_pin == $past(s_r.aux[asu_pkg::AUX_INV]);
	endproperty
	a_start_level: assert property (p_start_level) else $error("start bit ignores line inversion");

	property p_par_even;
		@(posedge mclk) disable iff (!rstn)
			(ce && tx_en && s_r.tx_st == TX_IDLE && s_r.txfull && par_mode == asu_pkg::PAR_EVEN)
			|=> s_r.tpar == ^s_r.tsh;
	endproperty
	a_par_even: assert property (p_par_even) else $error("even parity bit wrong");

	property p_par_odd;
		@(posedge mclk) disable iff (!rstn)
			(ce && tx_en && s_r.tx_st == TX_IDLE && s_r.txfull && par_mode == asu_pkg::PAR_ODD)
			|=> s_r.tpar != ^s_r.tsh;
	endproperty
	a_par_odd: assert property (p_par_odd) else $error("odd parity bit wrong");

	property p_no_par;
		@(posedge mclk) disable iff (!rstn)
			(ce && tx_en && s_r.tx_st == TX_DATA && s_r.tcnt == 9'h000 && par_mode == asu_pkg::PAR_NONE
			&& s_r.tnbit == (eight ? 3'h7 : 3'h6))
			|=> s_r.tx_st == TX_STOP1 && s_r.tline;
	endproperty
	a_no_par: assert property (p_no_par) else $error("parity bit sent without parity");

	property p_stop2;
		@(posedge mclk) disable iff (!rstn)
			(ce && tx_en && s_r.tx_st == TX_STOP1 && s_r.tcnt == 9'h000 && s_r.mode[asu_pkg::MODE_SL])
			|=> s_r.tx_st == TX_STOP2 && s_r.tline;
	endproperty
	a_stop2: assert property (p_stop2) else $error("second stop bit missing");

	property p_in_off;
		@(posedge mclk) disable iff (!rstn) (ce && !power) |=> !serial_in_used;
	endproperty
	a_in_off: assert property (p_in_off) else $error("receive pin kept in serial use while powered down");

	property p_stop_mode;
		@(posedge mclk) disable iff (!rstn)
			(ce && !power && !s_r.mode[asu_pkg::MODE_TXE] && !s_r.mode[asu_pkg::MODE_RXE])
			|=> s_r.tx_st == TX_IDLE && !s_r.txfull && serial_out_oe_n && !serial_in_used;
	endproperty
	a_stop_mode: assert property (p_stop_mode) else $error("unit active in stop mode");

	property p_rx_load;
		@(posedge mclk) disable iff (!rstn)
			(ce && power && rif.done && !s_r.rxfull) |=> s_r.rxfull && s_r.rxbuf == $past(rif.data);
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("received character not buffered");
endmodule : asu_top

// >>> tb/asu_remote_node.sv
`timescale 1ns/1ps
// far-end node: plays a prepared frame onto our receive line
module asu_remote_node #(
	parameter int BIT_CYC = 16 // must match twice the divisor
) (
	input wire logic mclk,
	input wire logic go,
	input wire logic [15:0] frame,
	input wire logic [3:0] nbits,
	output logic line
);
	// pulled-up line, so it rests high between frames
	initial line = 1'b1;
	// frame bit 0 leaves first, one bit time each
	// go is sampled at a plain edge, so no event qualifier is needed
	always @(posedge mclk) begin
		if (go) begin
			for (int i = 0; i < nbits; i++) begin
				line <= frame[i];
				repeat (BIT_CYC) @(posedge mclk);
			end
			line <= 1'b1;
		end
	end
endmodule : asu_remote_node

// >>> tb/async_serial_mode_and_framing_tb_top.sv
`timescale 1ns/1ps
module async_serial_mode_and_framing_tb_top;
	logic mclk;
	logic rstn = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wr_data = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] rd_data;
	logic rx_line; // driven by the remote node
	logic serial_out_pin;
	logic serial_out_oe_n;
	logic serial_in_used;
	logic rmt_go = 1'b0;
	logic [15:0] rmt_frame = 16'hFFFF;
	logic [3:0] rmt_n = 4'h0;
	int errors = 0;
	int tests_run = 0;
	// transmit cases: data, mode format bits, aux
	logic [7:0] td [8] = '{8'h55, 8'h55, 8'h55, 8'h36, 8'h87, 8'h07, 8'h07, 8'h07};
	logic [7:0] tm [8] = '{8'h1C, 8'h1C, 8'h1C, 8'h12, 8'h04, 8'h0C, 8'h1C, 8'h14};
	logic [7:0] ta [8] = '{8'h16, 8'h14, 8'h15, 8'h16, 8'h16, 8'h16, 8'h16, 8'h14};
	// receive cases: data, mode, aux, line corruption mask, error flags
	logic [7:0] rv [8] = '{8'hA5, 8'hA5, 8'h3C, 8'h3C, 8'h5A, 8'hB5, 8'h66, 8'hC3};
	logic [7:0] rm [8] = '{8'h1C, 8'h1C, 8'h14, 8'h0C, 8'h04, 8'h00, 8'h04, 8'h06};
	logic [7:0] ra [8] = '{8'h16, 8'h16, 8'h16, 8'h16, 8'h14, 8'h16, 8'h16, 8'h16};
	logic [15:0] rx_x [8] = '{16'h0, 16'h0200, 16'h0200, 16'h0200, 16'h0, 16'h0, 16'h0200, 16'h0400};
	logic [7:0] re [8] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};

	// ce held high: freezing is not part of this block's rules
	asu_top i_dut (
		.mclk(mclk), .rstn(rstn), .ce(1'b1), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .serial_in_pin(rx_line),
		.serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n), .serial_in_used(serial_in_used)
	);
	asu_remote_node i_remote (.mclk(mclk), .go(rmt_go), .frame(rmt_frame), .nbits(rmt_n), .line(rx_line));

	// 100 ns clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic tally_and_finish;
		$display("tests_run=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one-cycle write strobe
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask : reg_wr

	// read data only stands in the cycle after the strobe
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		chk({8'h00, rd_data}, {8'h00, e});
	endtask : rd_chk

	// expected line bits, first bit at index 0, idle ones above
	function automatic void mk(input logic [7:0] d, input logic [7:0] m, input logic lsb,
		output logic [15:0] f, output int n);
		int w;
		logic p;
		w = m[2] ? 8 : 7;
		f = 16'hFFFE;
		p = 1'b0;
		for (int i = 0; i < w; i++) begin
			f[i + 1] = lsb ? d[i] : d[w - 1 - i];
			p ^= d[i];
		end
		n = w + 1;
		if (m[4:3] != 2'b00) begin
			f[n] = m[4] & (m[3] ? p : ~p);
			n++;
		end
		n = n + 1 + int'(m[1]);
	endfunction : mk

	// enables drop in the same write as the mode format change, before the aux write; master stays on
	task automatic cfg(input logic [7:0] m, input logic [7:0] a);
		reg_wr(asu_pkg::ADDR_MODE, 8'h80 | m);
		reg_wr(asu_pkg::ADDR_AUX, a);
		reg_wr(asu_pkg::ADDR_MODE, 8'hE0 | m);
		repeat (2) @(negedge mclk);
		chk({14'h0000, serial_out_oe_n, serial_in_used}, 16'h0001);
	endtask : cfg

	// send one character and sample each bit mid-way
	task automatic tx(input logic [7:0] d, input logic [7:0] m, input logic [7:0] a);
		logic [15:0] f;
		logic [15:0] g;
		int n;
		int w;
		mk(d, m, a[1], f, n);
		reg_wr(asu_pkg::ADDR_TXBUF, d);
		g = 16'hFFFF;
		w = 0;
		while (serial_out_pin !== a[0] && w < 40) begin
			@(negedge mclk);
			w++;
		end
		repeat (8) @(negedge mclk);
		for (int i = 0; i < n; i++) begin
			g[i] = serial_out_pin ^ a[0];
			repeat (16) @(negedge mclk);
		end
		chk(g, f);
	endtask : tx

	// remote node sends a frame, possibly corrupted by mask x
	task automatic rx_send(input logic [7:0] d, input logic [7:0] m, input logic lsb, input logic [15:0] x);
		logic [15:0] f;
		int n;
		mk(d, m, lsb, f, n);
		@(posedge mclk);
		rmt_frame <= f ^ x;
		rmt_n <= 4'(n);
		rmt_go <= 1'b1;
		@(posedge mclk);
		rmt_go <= 1'b0;
		repeat (n * 16 + 4) @(posedge mclk);
	endtask : rx_send

	task automatic rx(input logic [7:0] d, input logic [7:0] m, input logic lsb, input logic [15:0] x,
		input logic [7:0] e);
		rx_send(d, m, lsb, x);
		rd_chk(asu_pkg::ADDR_RXERR, e);
		rd_chk(asu_pkg::ADDR_RXBUF, m[2] ? d : {1'b0, d[6:0]});
		rd_chk(asu_pkg::ADDR_RXERR, 8'h00);
	endtask : rx

	// hang guard, well beyond the few thousand cycles needed
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		@(negedge mclk);
		chk({13'h0000, serial_out_pin, serial_out_oe_n, serial_in_used}, 16'h0006);
		rd_chk(asu_pkg::ADDR_MODE, 8'h01);
		rd_chk(asu_pkg::ADDR_AUX, 8'h16);
		rd_chk(asu_pkg::ADDR_DIV, 8'hFF);
		rd_chk(16'hFF9F, 8'h00);
		reg_wr(asu_pkg::ADDR_DIV, 8'h08);
		// every parity scheme, both orders, inversion, both lengths
		for (int i = 0; i < 8; i++) begin
			cfg(tm[i], ta[i]);
			tx(td[i], tm[i], ta[i]);
		end
		// last case: low second stop must be ignored
		for (int i = 0; i < 8; i++) begin
			cfg(rm[i], ra[i]);
			rx(rv[i], rm[i], ra[i][1], rx_x[i], re[i]);
		end
		// the low second stop starts an all-ones character
		repeat (220) @(posedge mclk);
		rd_chk(asu_pkg::ADDR_RXBUF, 8'hFF);
		rd_chk(asu_pkg::ADDR_RXERR, 8'h00);
		// shared-bus use: both parity select bits kept at zero
		cfg(8'h04, 8'h16);
		tx(8'hC1, 8'h04, 8'h16);
		// both directions at once
		cfg(8'h1C, 8'h16);
		fork
			tx(8'h96, 8'h1C, 8'h16);
			rx(8'h69, 8'h1C, 1'b1, 16'h0000, 8'h00);
		join
		// shutdown with a full buffer, an error and a frame in flight
		rx_send(8'hA5, 8'h1C, 1'b1, 16'h0200);
		reg_wr(asu_pkg::ADDR_TXBUF, 8'h5A);
		repeat (20) @(posedge mclk);
		rd_chk(asu_pkg::ADDR_TXSTAT, 8'h01);
		reg_wr(asu_pkg::ADDR_MODE, 8'h9C);
		rd_chk(asu_pkg::ADDR_TXSTAT, 8'h00);
		chk({14'h0000, serial_out_oe_n, serial_in_used}, 16'h0002);
		reg_wr(asu_pkg::ADDR_MODE, 8'h1C);
		rd_chk(asu_pkg::ADDR_RXBUF, 8'h00);
		rd_chk(asu_pkg::ADDR_RXERR, 8'h00);
		rd_chk(asu_pkg::ADDR_MODE, 8'h1C);
		chk({13'h0000, serial_out_pin, serial_out_oe_n, serial_in_used}, 16'h0006);
		tally_and_finish();
	end
endmodule : async_serial_mode_and_framing_tb_top
